// [include/owi_pkg.sv]
// constants shared by the one-time-programmable wiper serial slave
package owi_pkg;
   // ----------------------------------------------------------------
   // addressing and framing
   // ----------------------------------------------------------------
   localparam logic [5:0] OWI_DEV_ADDR   = 6'h16;   // binary 010110
   localparam logic [3:0] OWI_BITS_BYTE  = 4'h8;    // data bits per byte
   localparam logic [3:0] OWI_ACK_SLOT   = 4'h9;    // ninth pulse
   localparam logic [3:0] OWI_CNT_ZERO   = 4'h0;
   localparam int         OWI_RW_POS     = 0;       // direction bit
   localparam int         OWI_SEL_POS    = 1;       // address select bit
   localparam int         OWI_PROG_POS   = 7;       // fuse-program bit
   localparam logic       OWI_DIR_WRITE  = 1'b0;
   localparam logic       OWI_DIR_READ   = 1'b1;
   // ----------------------------------------------------------------
   // wiper and fuse validation codes
   // ----------------------------------------------------------------
   localparam int         OWI_WIPER_W    = 6;
   localparam logic [5:0] OWI_WIPER_MID  = 6'h20;
   localparam logic [1:0] OWI_FUSE_READY = 2'h0;
   localparam logic [1:0] OWI_FUSE_TEST  = 2'h1;
   localparam logic [1:0] OWI_FUSE_FATAL = 2'h2;
   localparam logic [1:0] OWI_FUSE_DONE  = 2'h3;
   // ----------------------------------------------------------------
   // transfer states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [5:0] {
      OWI_ST_IDLE  = 6'h01,
      OWI_ST_ADDR  = 6'h02,
      OWI_ST_INSTR = 6'h04,
      OWI_ST_WDATA = 6'h08,
      OWI_ST_RDATA = 6'h10,
      OWI_ST_SKIP  = 6'h20
   } owi_state_t;
endpackage

// [include/owi_pins_if.sv]
// carrier between the pin conditioner and the transfer engine
`timescale 1ns/1ps
`default_nettype none
interface owi_pins_if;
   logic scl_raw;
   logic sda_raw;
   logic sda_lvl;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   modport cond (
      input  scl_raw,
      input  sda_raw,
      output sda_lvl,
      output scl_rise,
      output scl_fall,
      output start_det,
      output stop_det
   );
   modport core (
      output scl_raw,
      output sda_raw,
      input  sda_lvl,
      input  scl_rise,
      input  scl_fall,
      input  start_det,
      input  stop_det
   );
endinterface
`default_nettype wire

// [rtl/owi_pin_cond.sv]
// two-stage synchronisers and edge, start and stop detection
`timescale 1ns/1ps
`default_nettype none
module owi_pin_cond #(
   parameter int SYNC_STAGES = 2
) (
   input  wire logic  i_clk_sys,
   input  wire logic  i_rst,
   owi_pins_if.cond   pins
);
   import owi_pkg::*;

   // fewer than two stages would let a metastable level reach the decode
   if (SYNC_STAGES < 2) begin : g_bad_stages
      $error("owi_pin_cond needs at least two synchroniser stages");
   end

   // ----------------------------------------------------------------
   // synchronisers; only the last stage and the delayed copy are read
   // ----------------------------------------------------------------
   logic [SYNC_STAGES-1:0] scl_sync_r;
   logic [SYNC_STAGES-1:0] sda_sync_r;
   logic                   scl_d_r;
   logic                   sda_d_r;
   wire                    scl_s = scl_sync_r[SYNC_STAGES-1];
   wire                    sda_s = sda_sync_r[SYNC_STAGES-1];

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         scl_sync_r <= '1;
         sda_sync_r <= '1;
         scl_d_r    <= 1'b1;
         sda_d_r    <= 1'b1;
      end else begin
         scl_sync_r <= {scl_sync_r[SYNC_STAGES-2:0], pins.scl_raw};
         sda_sync_r <= {sda_sync_r[SYNC_STAGES-2:0], pins.sda_raw};
         scl_d_r    <= scl_s;
         sda_d_r    <= sda_s;
      end
   end

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   assign pins.sda_lvl   = sda_s;
   assign pins.scl_rise  = scl_s & ~scl_d_r;
   assign pins.scl_fall  = ~scl_s & scl_d_r;
   // data moving while the clock is high marks frame edges
   assign pins.start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign pins.stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
endmodule
`default_nettype wire

// [rtl/owi_slave.sv]
// two-wire slave of a one-time-programmable 64-step wiper
//
// What this block does
// - address byte: fixed six bits, select, direction
// - answer only when select bit matches pin
// - acknowledge address on ninth pulse when matched
// - write is address, instruction, data, each acked
// - program bit set on a ready part with no fuse fault freezes wiper permanently
// - six-bit wiper code from data bits five-zero
// - read data follows address acknowledge directly
// - validation bits report fuse state
// - validation one-one locks out further adjustments
// - nine pulses per byte, data changes while low
// - further data bytes update wiper again
// - repeated reads return the same byte again
// - direction bit zero writes, one reads
// - read byte: validation bits then wiper code
// - unprogrammed part starts at midscale
`timescale 1ns/1ps
`default_nettype none
module owi_slave (
   input  wire logic                         i_clk_sys,
   input  wire logic                         i_rst,
   input  wire logic                         i_scl,
   input  wire logic                         i_sda,
   input  wire logic                         i_addr_select_bit,
   input  wire logic [1:0]                   i_fuse_state,
   input  wire logic [owi_pkg::OWI_WIPER_W-1:0] i_fuse_wiper,
   input  wire logic                         i_fuse_fault,
   output logic                              o_sda_o,
   output logic                              o_sda_oe,
   output logic [owi_pkg::OWI_WIPER_W-1:0]   o_wiper_code,
   output logic                              o_fuse_check_hi,
   output logic                              o_fuse_check_lo,
   output logic                              o_fuse_blow
);
   import owi_pkg::*;

   // ----------------------------------------------------------------
   // pin conditioning
   // ----------------------------------------------------------------
   owi_pins_if pins ();
   logic sel_s1_r;
   logic sel_s2_r;

   assign pins.scl_raw = i_scl;
   assign pins.sda_raw = i_sda;

   owi_pin_cond #(
      .SYNC_STAGES (2)
   ) u_cond (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .pins      (pins)
   );

   // the select strap is a pin too, so it is synchronised as well
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sel_s1_r <= 1'b0;
         sel_s2_r <= 1'b0;
      end else begin
         sel_s1_r <= i_addr_select_bit;
         sel_s2_r <= sel_s1_r;
      end
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   owi_state_t             st_r,      st_nxt;
   logic [3:0]             cnt_r,     cnt_nxt;
   logic [7:0]             rx_r,      rx_nxt;
   logic [7:0]             tx_r,      tx_nxt;
   logic                   oe_r,      oe_nxt;
   logic                   prog_r,    prog_nxt;
   logic                   nack_r,    nack_nxt;
   logic [OWI_WIPER_W-1:0] wiper_r,   wiper_nxt;
   logic [1:0]             fuse_r,    fuse_nxt;
   logic                   blow_r,    blow_nxt;
   logic                   init_r;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire       fall_byte  = pins.scl_fall & (cnt_r == OWI_BITS_BYTE);
   wire       fall_ack   = pins.scl_fall & (cnt_r == OWI_ACK_SLOT);
   wire       rise_bit   = pins.scl_rise & (cnt_r < OWI_ACK_SLOT);
   wire [6:0] addr_want  = {OWI_DEV_ADDR, sel_s2_r};
   wire       addr_hit   = (rx_r[7:OWI_SEL_POS] == addr_want);
   wire       is_read    = (rx_r[OWI_RW_POS] == OWI_DIR_READ);
   wire       locked     = (fuse_r == OWI_FUSE_DONE);
   wire       can_prog   = (fuse_r == OWI_FUSE_READY);
   // validation bits on top, wiper code below
   wire [7:0] read_byte  = {fuse_r, wiper_r};
   // only data bits five to zero reach the wiper
   wire [OWI_WIPER_W-1:0] new_code = rx_r[OWI_WIPER_W-1:0];
   wire [3:0] cnt_inc    = cnt_r + 4'h1;
   wire [3:0] tx_idx     = OWI_BITS_BYTE - 4'h1 - cnt_r;

   // ----------------------------------------------------------------
   // transfer engine
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt    = st_r;
      cnt_nxt   = cnt_r;
      rx_nxt    = rx_r;
      tx_nxt    = tx_r;
      oe_nxt    = oe_r;
      prog_nxt  = prog_r;
      nack_nxt  = nack_r;
      wiper_nxt = wiper_r;
      fuse_nxt  = fuse_r;
      blow_nxt  = 1'b0;
      if (pins.start_det) begin
         // a start, repeated or not, always restarts address capture
         st_nxt  = OWI_ST_ADDR;
         cnt_nxt = OWI_CNT_ZERO;
         oe_nxt  = 1'b0;
      end else if (pins.stop_det) begin
         st_nxt  = OWI_ST_IDLE;
         cnt_nxt = OWI_CNT_ZERO;
         oe_nxt  = 1'b0;
      end else if (st_r != OWI_ST_IDLE && st_r != OWI_ST_SKIP) begin
         if (rise_bit) begin
            cnt_nxt = cnt_inc;
            if (cnt_r < OWI_BITS_BYTE) begin
               rx_nxt = {rx_r[6:0], pins.sda_lvl};
            end else begin
               nack_nxt = pins.sda_lvl;   // master's answer in read
            end
         end
         unique case (st_r)
            OWI_ST_ADDR: begin
               if (fall_byte) begin
                  if (addr_hit) begin
                     oe_nxt = 1'b1;
                  end else begin
                     st_nxt = OWI_ST_SKIP;   // not ours: stay off the bus
                  end
               end else if (fall_ack) begin
                  cnt_nxt = OWI_CNT_ZERO;
                  if (is_read) begin
                     st_nxt = OWI_ST_RDATA;
                     tx_nxt = read_byte;
                     oe_nxt = ~read_byte[7];
                  end else begin
                     st_nxt = OWI_ST_INSTR;
                     oe_nxt = 1'b0;
                  end
               end
            end
            OWI_ST_INSTR: begin
               if (fall_byte) begin
                  oe_nxt   = 1'b1;
                  prog_nxt = rx_r[OWI_PROG_POS];   // rest ignored
               end else if (fall_ack) begin
                  cnt_nxt = OWI_CNT_ZERO;
                  oe_nxt  = 1'b0;
                  st_nxt  = OWI_ST_WDATA;
               end
            end
            OWI_ST_WDATA: begin
               if (fall_byte) begin
                  oe_nxt = 1'b1;
                  // every further byte with the same instruction lands unless validation is one-one
                  if (!locked) begin
                     wiper_nxt = new_code;
                  end
                  if (prog_r && can_prog) begin
                     blow_nxt = 1'b1;
                     fuse_nxt = i_fuse_fault ? OWI_FUSE_FATAL
                                             : OWI_FUSE_DONE;
                  end
               end else if (fall_ack) begin
                  // instruction is kept until the next instruction byte
                  cnt_nxt = OWI_CNT_ZERO;
                  oe_nxt  = 1'b0;
               end
            end
            OWI_ST_RDATA: begin
               if (pins.scl_fall && cnt_r < OWI_BITS_BYTE) begin
                  oe_nxt = ~tx_r[tx_idx[2:0]];
               end else if (fall_byte) begin
                  oe_nxt = 1'b0;          // free the line for the master
               end else if (fall_ack) begin
                  cnt_nxt = OWI_CNT_ZERO;
                  if (nack_r) begin
                     // master now owns the line to stop
                     st_nxt = OWI_ST_SKIP;
                     oe_nxt = 1'b0;
                  end else begin
                     tx_nxt = read_byte;
                     oe_nxt = ~read_byte[7];
                  end
               end
            end
            default: begin
               st_nxt = OWI_ST_IDLE;
               oe_nxt = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         st_r    <= OWI_ST_IDLE;
         cnt_r   <= OWI_CNT_ZERO;
         rx_r    <= 8'h00;
         tx_r    <= 8'h00;
         oe_r    <= 1'b0;
         prog_r  <= 1'b0;
         nack_r  <= 1'b1;
         blow_r  <= 1'b0;
         init_r  <= 1'b1;
         wiper_r <= OWI_WIPER_MID;
         fuse_r  <= OWI_FUSE_READY;
      end else begin
         st_r    <= st_nxt;
         cnt_r   <= cnt_nxt;
         rx_r    <= rx_nxt;
         tx_r    <= tx_nxt;
         oe_r    <= oe_nxt;
         prog_r  <= prog_nxt;
         nack_r  <= nack_nxt;
         blow_r  <= blow_nxt;
         init_r  <= 1'b0;
         if (init_r) begin
            // fuse array is sampled once, the cycle after reset release
            fuse_r <= i_fuse_state;
            if (i_fuse_state == OWI_FUSE_DONE) begin
               wiper_r <= i_fuse_wiper;
            end
         end else begin
            fuse_r  <= fuse_nxt;
            wiper_r <= wiper_nxt;
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs, all from flip-flops
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_sda_o <= 1'b0;
      end else begin
         o_sda_o <= 1'b0;   // open drain: only ever pulls low
      end
   end

   assign o_sda_oe        = oe_r;
   assign o_wiper_code    = wiper_r;
   assign o_fuse_check_hi = fuse_r[1];
   assign o_fuse_check_lo = fuse_r[0];
   assign o_fuse_blow     = blow_r;
endmodule
`default_nettype wire

// [testbench/owi_slave_assertions.sv]
// concurrent checks on the ports of the wiper serial slave
`timescale 1ns/1ps
`default_nettype none
module owi_slave_assertions (
   input wire logic                              i_clk_sys,
   input wire logic                              i_rst,
   input wire logic                              i_scl,
   input wire logic                              i_sda,
   input wire logic                              i_addr_select_bit,
   input wire logic [1:0]                        i_fuse_state,
   input wire logic [owi_pkg::OWI_WIPER_W-1:0]   i_fuse_wiper,
   input wire logic                              i_fuse_fault,
   input wire logic                              o_sda_o,
   input wire logic                              o_sda_oe,
   input wire logic [owi_pkg::OWI_WIPER_W-1:0]   o_wiper_code,
   input wire logic                              o_fuse_check_hi,
   input wire logic                              o_fuse_check_lo,
   input wire logic                              o_fuse_blow
);
   import owi_pkg::*;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // ---------------------------------------------------------------
   // line driving
   // ---------------------------------------------------------------
   a_sda_low_only: assert property (o_sda_o == 1'b0)
      else $error("data line driven high");
   // slave turns the line only while the bus clock is low
   a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
      else $error("data line moved while clock high");
   // ---------------------------------------------------------------
   // reset and fuse load
   // ---------------------------------------------------------------
   a_reset_values: assert property ($fell(i_rst) |->
      o_wiper_code == OWI_WIPER_MID && !o_sda_oe && !o_fuse_blow
      && !o_fuse_check_hi && !o_fuse_check_lo)
      else $error("wrong values out of reset");
   a_fuse_load: assert property ($fell(i_rst) |=>
      {o_fuse_check_hi, o_fuse_check_lo} == i_fuse_state)
      else $error("validation bits not loaded");
   a_fused_wiper: assert property ($fell(i_rst) &&
      i_fuse_state == OWI_FUSE_DONE |=> o_wiper_code == i_fuse_wiper)
      else $error("fused wiper not loaded");
   // ---------------------------------------------------------------
   // wiper updates and programming
   // ---------------------------------------------------------------
   a_wiper_at_ack: assert property ($changed(o_wiper_code) &&
      !$past(i_rst, 2) |-> $rose(o_sda_oe))
      else $error("wiper moved outside a data acknowledge");
   a_locked_wiper: assert property (o_fuse_check_hi &&
      o_fuse_check_lo && $past(o_fuse_check_hi && o_fuse_check_lo)
      |-> $stable(o_wiper_code))
      else $error("wiper moved after programming");
   a_blow_pulse: assert property (o_fuse_blow |=> !o_fuse_blow)
      else $error("blow request longer than one cycle");
   a_blow_ready: assert property ($rose(o_fuse_blow) |->
      !$past(o_fuse_check_hi) && !$past(o_fuse_check_lo))
      else $error("blow requested while not ready");
   a_blow_marks: assert property (o_fuse_blow |->
      ##[0:2] o_fuse_check_hi)
      else $error("validation bits not updated by blow");
endmodule
bind owi_slave owi_slave_assertions i_owi_slave_assertions (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda),
   .i_addr_select_bit(i_addr_select_bit), .i_fuse_state(i_fuse_state),
   .i_fuse_wiper(i_fuse_wiper), .i_fuse_fault(i_fuse_fault),
   .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_wiper_code(o_wiper_code),
   .o_fuse_check_hi(o_fuse_check_hi), .o_fuse_check_lo(o_fuse_check_lo),
   .o_fuse_blow(o_fuse_blow)
);
`default_nettype wire

// [testbench/owi_i2c_master.sv]
// behavioural two-wire bus master facing the wiper slave
`timescale 1ns/1ps
`default_nettype none
module owi_i2c_master (
   input  wire logic i_clk_sys,
   input  wire logic i_sda,
   output var  logic o_scl,
   output var  logic o_sda_low
);
   // ---------------------------------------------------------------
   // bus phases; the clock stands high between frames
   // ---------------------------------------------------------------
   initial begin
      o_scl     = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic start_c();
      o_sda_low = 1'b0;
      o_scl     = 1'b1;
      tick(4);
      o_sda_low = 1'b1;
      tick(4);
      o_scl = 1'b0;
   endtask
   // data goes low while the clock is low, before the tenth pulse
   task automatic stop_c();
      tick(2);
      o_sda_low = 1'b1;
      tick(4);
      o_scl = 1'b1;
      tick(4);
      o_sda_low = 1'b0;
      tick(4);
   endtask
   // nine pulses, msb first; ninth slot sent as given, one = nack
   task automatic xfer9(input logic [8:0] w,
                        output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         tick(2);
         o_sda_low = ~w[i];
         tick(4);
         o_scl = 1'b1;
         tick(1);
         r[i] = i_sda;
         tick(1);
         o_scl = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the wiper serial slave
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import owi_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst     = 1'b1;
   logic        sel     = 1'b0;
   logic        fault   = 1'b0;
   logic [1:0]  fstate  = 2'h0;
   logic [5:0]  fwiper  = 6'h00;
   logic [31:0] seed    = 32'hDE82;
   logic        scl, sda_low, sda_o, sda_oe, blow, chk_hi, chk_lo;
   logic [5:0]  wiper;
   wire  logic  sda;
   int          n_fail = 0, tests_run = 0, n_blow = 0, exp_blow = 0;
   int          m_wiper, m_fuse;
   // pull-up: released line reads high
   assign sda = !(sda_low || (sda_oe && !sda_o));
   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (blow === 1'b1) n_blow <= n_blow + 1;
   owi_slave i_owi_slave (
      .i_clk_sys(clk_sys), .i_rst(rst), .i_scl(scl), .i_sda(sda),
      .i_addr_select_bit(sel), .i_fuse_state(fstate),
      .i_fuse_wiper(fwiper), .i_fuse_fault(fault), .o_sda_o(sda_o),
      .o_sda_oe(sda_oe), .o_wiper_code(wiper), .o_fuse_check_hi(chk_hi),
      .o_fuse_check_lo(chk_lo), .o_fuse_blow(blow)
   );
   owi_i2c_master i_owi_i2c_master (
      .i_clk_sys(clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low)
   );
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_state();
      chk({2'h0, wiper}, 8'(m_wiper), "wiper");
      chk({6'h00, chk_hi, chk_lo}, 8'(m_fuse), "fuse");
      chk(8'(n_blow), 8'(exp_blow), "blow");
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic rst_dut(input logic [1:0] s, input logic f,
                          input logic p);
      rst    = 1'b1;
      fstate = s;
      fault  = f;
      sel    = p;
      fwiper = 6'(rnd());
      repeat (6) @(posedge clk_sys);
      #1;
      rst    = 1'b0;
      m_fuse = s;
      m_wiper = (s == OWI_FUSE_DONE) ? fwiper : OWI_WIPER_MID;
      repeat (6) @(posedge clk_sys);
      #1;
      chk_state();
   endtask
   task automatic wr(input logic [7:0] adr, input logic prog, input int n);
      logic [8:0] r;
      logic [7:0] d;
      logic       hit;
      hit = adr[7:1] == {OWI_DEV_ADDR, sel};
      i_owi_i2c_master.start_c();
      i_owi_i2c_master.xfer9({adr, 1'b1}, r);
      chk(8'(r[0]), 8'(!hit), "addr ack");
      d = 8'(rnd());
      i_owi_i2c_master.xfer9({prog, d[6:0], 1'b1}, r);
      chk(8'(r[0]), 8'(!hit), "instr ack");
      for (int i = 0; i < n; i++) begin
         d = 8'(rnd());
         i_owi_i2c_master.xfer9({d, 1'b1}, r);
         chk(8'(r[0]), 8'(!hit), "data ack");
         if (hit && m_fuse != 3) m_wiper = d[5:0];
         if (hit && prog && m_fuse == 0) begin
            exp_blow++;
            m_fuse = fault ? 2 : 3;
         end
      end
      i_owi_i2c_master.stop_c();
      chk_state();
   endtask
   task automatic rd(input logic [7:0] adr, input int n);
      logic [8:0] r;
      logic [7:0] e;
      logic       hit;
      hit = adr[7:1] == {OWI_DEV_ADDR, sel};
      i_owi_i2c_master.start_c();
      i_owi_i2c_master.xfer9({adr, 1'b1}, r);
      chk(8'(r[0]), 8'(!hit), "addr ack");
      for (int i = 0; i < n; i++) begin
         i_owi_i2c_master.xfer9({8'hFF, i == n - 1}, r);
         e = hit ? 8'(m_fuse * 64 + m_wiper) : 8'hFF;
         chk(r[8:1], e, "read");
      end
      i_owi_i2c_master.stop_c();
   endtask
   // ---------------------------------------------------------------
   // scenarios: every fuse state, then a fatal blow
   // ---------------------------------------------------------------
   initial begin
      logic [1:0] s;
      logic       p;
      i_owi_i2c_master.tick(1);
      for (int k = 0; k < 5; k++) begin
         s = (k == 4) ? 2'h0 : 2'(k);
         p = k[0];
         rst_dut(s, k == 4, p);
         rd({OWI_DEV_ADDR, p, OWI_DIR_READ}, 2);
         rd({OWI_DEV_ADDR, !p, OWI_DIR_READ}, 1);
         wr({OWI_DEV_ADDR ^ 6'(1 << k), p, OWI_DIR_WRITE}, 1'b0, 1);
         wr({OWI_DEV_ADDR, !p, OWI_DIR_WRITE}, 1'b0, 1);
         wr({OWI_DEV_ADDR, p, OWI_DIR_WRITE}, 1'b0, 3);
         wr({OWI_DEV_ADDR, p, OWI_DIR_WRITE}, 1'b1, 2);
         rd({OWI_DEV_ADDR, p, OWI_DIR_READ}, 1);
         wr({OWI_DEV_ADDR, p, OWI_DIR_WRITE}, 1'b0, 1);
         $display("test %0d done, fuse state %0d", k, s);
      end
      end_sim();
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      n_fail++;
      $display("[FAIL] %0t run did not finish", $time);
      end_sim();
   end
endmodule
`default_nettype wire
